//--- hdl/abm_pkg.sv
// Shared types and constants of the asynchronous bus cycle master.
package abm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Cycle kinds and operand sizes.
   typedef enum logic [1:0] {
      ABM_OP_READ  = 2'h0,
      ABM_OP_WRITE = 2'h1,
      ABM_OP_RMW   = 2'h2,
      ABM_OP_IACK  = 2'h3
   } abm_op_t;

   typedef enum logic [1:0] {
      ABM_SZ_BYTE = 2'h0,
      ABM_SZ_WORD = 2'h1,
      ABM_SZ_LONG = 2'h2
   } abm_size_t;

   // Sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RUN  = 4'h2,
      ST_BUS_ERROR_IN = 4'h4,
      ST_MOD  = 4'h8
   } abm_state_t;

   ////////////////////////////////////////////////////////////////////////
   // Request from the core, answer to the core, and the bus pins.
   typedef struct packed {
      abm_op_t     op;
      abm_size_t   size;
      logic [2:0]  fc;
      logic [23:0] addr;
      logic [31:0] wdata;
      logic [2:0]  level;
   } abm_req_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic        err;
   } abm_resp_t;

   typedef struct packed {
      logic [23:1] address;
      logic [2:0]  function_code;
      logic        address_strobe_n;
      logic        upper_byte_strobe_n;
      logic        lower_byte_strobe_n;
      logic        rw;
      logic [15:0] data_out;
      logic        data_oe_n;
   } abm_pins_t;

   ////////////////////////////////////////////////////////////////////////
   // Bus state numbers; one bus state lasts one clock.
   localparam logic [3:0] STEP_ONE = 4'h1;
   localparam logic [3:0] STEP_S0  = 4'h0;
   localparam logic [3:0] STEP_S1  = 4'h1;
   localparam logic [3:0] STEP_S2  = 4'h2;
   localparam logic [3:0] STEP_S3  = 4'h3;
   localparam logic [3:0] STEP_S4  = 4'h4;
   localparam logic [3:0] STEP_S6  = 4'h6;
   localparam logic [3:0] STEP_S7  = 4'h7;
   localparam logic [3:0] STEP_END = 4'h8;
   localparam logic [2:0] CNT_ONE  = 3'h1;
   localparam logic [2:0] BUS_ERROR_IN_S8  = 3'h3;
   localparam logic [2:0] BUS_ERROR_IN_S9  = 3'h4;
   localparam logic [2:0] MOD_LAST = 3'h2;

   // Encodings and fixed values.
   localparam logic [2:0]  FC_CPU_SPACE = 3'h7;
   localparam logic [19:0] IACK_HIGH    = 20'hFFFFF;
   localparam logic [7:0]  TAS_SET      = 8'h80;
   localparam logic [22:0] WORD_STEP    = 23'h000001;

   localparam abm_pins_t PINS_IDLE = '{
      address: 23'h000000, function_code: 3'h0, address_strobe_n: 1'b1,
      upper_byte_strobe_n: 1'b1, lower_byte_strobe_n: 1'b1, rw: 1'b1,
      data_out: 16'h0000, data_oe_n: 1'b1};

endpackage

//--- hdl/abm_sync.sv
// Two-flop synchroniser for the bus termination and data inputs.
`timescale 1ns/1ps
`default_nettype none
module abm_sync #(
   parameter int                 WIDTH     = 1,
   parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             reset_n,
   // Raw and synchronised levels.
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // The first stage feeds only the second.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         meta <= RESET_VAL;
         q    <= RESET_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

//--- hdl/abm_bus_master.sv
// Bus cycle sequencer: read, write, read-modify-write and interrupt acknowledge.
`timescale 1ns/1ps
`default_nettype none
module abm_bus_master import abm_pkg::*; (
   // Clock and reset.
   input  wire logic      clock,
   input  wire logic      reset_n,
   // Cycle request from the core.
   input  wire logic      req_valid,
   input  wire abm_req_t  req,
   output var  logic      req_ready,
   // Cycle answer to the core.
   output var  logic      done,
   output var  abm_resp_t resp,
   // Bus pins.
   output var  abm_pins_t pins,
   input  wire logic [15:0] data_in,
   input  wire logic      transfer_ack_n,
   input  wire logic      bus_error_in_n
);

   ////////////////////////////////////////////////////////////////////////
   // State and next values.
   abm_state_t state, next_state;
   logic [3:0] step, next_step;
   logic [2:0] cnt, next_cnt;
   abm_req_t   cur, next_cur;
   logic       second, next_second;
   logic       rmw_wr, next_rmw_wr;
   abm_pins_t  next_pins;
   abm_resp_t  next_resp;
   logic       next_done;
   logic [17:0] sync_q;
   // Termination and data pins pass two flops before use.
   abm_sync #(
      .WIDTH     (18),
      .RESET_VAL (18'h3FFFF)
   ) u_sync (
      .clock   (clock),
      .reset_n (reset_n),
      .d       ({transfer_ack_n, bus_error_in_n, data_in}),
      .q       (sync_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decoding of the current cycle.
   abm_req_t    req_eff;
   logic        ack_s, err_s, is_wr, is_rmw;
   logic        both_sel, uds_sel, lds_sel, long_first, hold_as;
   logic [7:0]  byte_in, wbyte;
   logic [15:0] din, rd16, wword;
   logic [31:0] rd_merge;
   logic [22:0] next_word_addr;

   assign ack_s = ~sync_q[17];
   assign err_s = ~sync_q[16];
   assign din   = sync_q[15:0];
   // An acknowledge cycle carries all-ones function code and level address.
   assign req_eff = (req.op == ABM_OP_IACK) ?
      abm_req_t'{op: req.op, size: req.size, fc: FC_CPU_SPACE,
        addr: {IACK_HIGH, req.level, 1'b0}, wdata: req.wdata,
        level: req.level} : req;

   assign is_wr      = (cur.op == ABM_OP_WRITE) || rmw_wr;
   assign is_rmw     = (cur.op == ABM_OP_RMW);
   assign both_sel   = (cur.size != ABM_SZ_BYTE) || (cur.op == ABM_OP_IACK);
   assign uds_sel    = both_sel || !cur.addr[0];
   assign lds_sel    = both_sel || cur.addr[0];
   assign long_first = (cur.size == ABM_SZ_LONG) && !second;
   // The read part of read-modify-write keeps the address strobe unless it failed.
   assign hold_as    = is_rmw && !rmw_wr && !resp.err;
   // Read data alignment: bytes land in the low byte.
   assign byte_in  = cur.addr[0] ? din[7:0] : din[15:8];
   assign rd16     = (cur.op == ABM_OP_IACK) ? {8'h00, din[7:0]} :
                     (cur.size == ABM_SZ_BYTE) ? {8'h00, byte_in} : din;
   assign rd_merge = long_first ? {rd16, 16'h0000} :
                     second ? {resp.rdata[31:16], rd16} : {16'h0000, rd16};
   // Write data: the modify step sets the top bit of the byte that was read.
   assign wbyte = rmw_wr ? (resp.rdata[7:0] | TAS_SET) : cur.wdata[7:0];
   assign wword = (cur.size == ABM_SZ_BYTE) ? {wbyte, wbyte} :
                  long_first ? cur.wdata[31:16] : cur.wdata[15:0];
   assign next_word_addr = cur.addr[23:1] + WORD_STEP;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: each bus state lasts one clock.
   always_comb begin
      next_state  = state;
      next_step   = step;
      next_cnt    = cnt;
      next_cur    = cur;
      next_second = second;
      next_rmw_wr = rmw_wr;
      next_pins   = pins;
      next_resp   = resp;
      next_done   = 1'b0;
      case (state)
         ST_IDLE: begin
            if (req_valid && req_ready) begin
               next_cur                = req_eff;
               next_second             = 1'b0;
               next_rmw_wr             = 1'b0;
               next_step               = STEP_S0;
               next_state              = ST_RUN;
               next_resp               = '0;
               next_pins.address       = req_eff.addr[23:1];
               next_pins.function_code = req_eff.fc;
               next_pins.rw            = 1'b1;
            end
         end
         ST_RUN: begin
            next_step = step + STEP_ONE;
            case (step)
               STEP_S1: begin
                  next_pins.address_strobe_n = 1'b0;
                  if (is_wr) begin
                     next_pins.rw = 1'b0;
                  end else begin
                     next_pins.upper_byte_strobe_n = !uds_sel;
                     next_pins.lower_byte_strobe_n = !lds_sel;
                  end
               end
               STEP_S2: begin
                  if (is_wr) begin
                     next_pins.data_oe_n = 1'b0;
                     next_pins.data_out  = wword;
                  end
               end
               STEP_S3: begin
                  if (is_wr) begin
                     next_pins.upper_byte_strobe_n = !uds_sel;
                     next_pins.lower_byte_strobe_n = !lds_sel;
                  end
               end
               STEP_S4: begin
                  if (ack_s) begin
                     next_resp.err = err_s;
                  end else if (err_s) begin
                     next_state = ST_BUS_ERROR_IN;
                     next_cnt   = 3'h0;
                     next_step  = step;
                  end else begin
                     next_step = step;
                  end
               end
               STEP_S6: begin
                  next_pins.upper_byte_strobe_n = 1'b1;
                  next_pins.lower_byte_strobe_n = 1'b1;
                  if (!hold_as) begin
                     next_pins.address_strobe_n = 1'b1;
                  end
                  if (!is_wr) begin
                     next_resp.rdata = rd_merge;
                  end
               end
               STEP_S7: begin
                  if (is_wr) begin
                     next_pins.data_oe_n = 1'b1;
                     next_pins.rw        = 1'b1;
                  end
               end
               STEP_END: begin
                  if (hold_as) begin
                     next_state = ST_MOD;
                     next_cnt   = 3'h0;
                  end else if (long_first && !resp.err) begin
                     next_second       = 1'b1;
                     next_step         = STEP_S0;
                     next_pins.address = next_word_addr;
                     next_pins.rw      = 1'b1;
                  end else begin
                     next_state = ST_IDLE;
                     next_done  = 1'b1;
                  end
               end
               default: ;
            endcase
         end
         ST_BUS_ERROR_IN: begin
            next_cnt = cnt + CNT_ONE;
            if (cnt == BUS_ERROR_IN_S8) begin
               next_pins.address_strobe_n    = 1'b1;
               next_pins.upper_byte_strobe_n = 1'b1;
               next_pins.lower_byte_strobe_n = 1'b1;
            end else if (cnt == BUS_ERROR_IN_S9) begin
               next_pins.data_oe_n = 1'b1;
               next_pins.rw        = 1'b1;
               next_resp.err       = 1'b1;
               next_state          = ST_IDLE;
               next_done           = 1'b1;
            end
         end
         ST_MOD: begin
            next_cnt = cnt + CNT_ONE;
            if (cnt == MOD_LAST) begin
               next_state  = ST_RUN;
               next_step   = STEP_S0;
               next_rmw_wr = 1'b1;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers; every output is a flop.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state     <= ST_IDLE;
         step      <= STEP_S0;
         cnt       <= 3'h0;
         cur       <= '0;
         second    <= 1'b0;
         rmw_wr    <= 1'b0;
         pins      <= PINS_IDLE;
         resp      <= '0;
         done      <= 1'b0;
         req_ready <= 1'b1;
      end else begin
         state     <= next_state;
         step      <= next_step;
         cnt       <= next_cnt;
         cur       <= next_cur;
         second    <= next_second;
         rmw_wr    <= next_rmw_wr;
         pins      <= next_pins;
         resp      <= next_resp;
         done      <= next_done;
         req_ready <= (next_state == ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the sequence.
   property p_word_strobes;
      @(posedge clock) disable iff (!reset_n)
      (state == ST_RUN && both_sel && step == STEP_S4)
         |-> (!pins.upper_byte_strobe_n && !pins.lower_byte_strobe_n);
   endproperty
   a_word_strobes: assert property (p_word_strobes)
      else $error("word cycle lacks both byte strobes");
   property p_byte_select;
      @(posedge clock) disable iff (!reset_n)
      (state == ST_RUN && !both_sel && step == STEP_S4)
         |-> (pins.upper_byte_strobe_n == cur.addr[0]
              && pins.lower_byte_strobe_n == !cur.addr[0]);
   endproperty
   a_byte_select: assert property (p_byte_select)
      else $error("byte strobe does not follow low address bit");
   property p_read_s2;
      @(posedge clock) disable iff (!reset_n)
      (state == ST_RUN && step == STEP_S1 && !is_wr)
         |=> (!pins.address_strobe_n && pins.rw && step == STEP_S2
              && (!pins.upper_byte_strobe_n || !pins.lower_byte_strobe_n));
   endproperty
   a_read_s2: assert property (p_read_s2)
      else $error("read strobes not asserted at S2");
   property p_wait;
      @(posedge clock) disable iff (!reset_n)
      (state == ST_RUN && step == STEP_S4 && !ack_s && !err_s)
         |=> (state == ST_RUN && step == STEP_S4);
   endproperty
   a_wait: assert property (p_wait)
      else $error("left S4 without a termination");
   property p_bus_error_in_hold;
      @(posedge clock) disable iff (!reset_n)
      (state == ST_RUN && step == STEP_S4 && err_s && !ack_s)
         |=> (!pins.address_strobe_n)[*4] ##1 pins.address_strobe_n ##1 done;
   endproperty
   a_bus_error_in_hold: assert property (p_bus_error_in_hold)
      else $error("bus error path timing wrong");
   property p_write_late;
      @(posedge clock) disable iff (!reset_n)
      (state == ST_RUN && is_wr && step == STEP_S2)
         |-> (!pins.rw && pins.upper_byte_strobe_n && pins.lower_byte_strobe_n)
             ##1 !pins.data_oe_n ##1 (!pins.upper_byte_strobe_n || !pins.lower_byte_strobe_n);
   endproperty
   a_write_late: assert property (p_write_late)
      else $error("write direction, data or strobes out of order");
   property p_write_end;
      @(posedge clock) disable iff (!reset_n)
      (state == ST_RUN && is_wr && step == STEP_S7)
         |-> (pins.upper_byte_strobe_n && pins.lower_byte_strobe_n)
             ##1 (pins.data_oe_n && pins.rw);
   endproperty
   a_write_end: assert property (p_write_end)
      else $error("write did not release the bus after S7");
   property p_rmw_hold;
      @(posedge clock) disable iff (!reset_n)
      (state == ST_MOD) |-> (!pins.address_strobe_n && pins.rw
                             && pins.upper_byte_strobe_n && pins.data_oe_n);
   endproperty
   a_rmw_hold: assert property (p_rmw_hold)
      else $error("bus changed during modify states");
   property p_iack;
      @(posedge clock) disable iff (!reset_n)
      (cur.op == ABM_OP_IACK && !pins.address_strobe_n)
         |-> (pins.function_code == FC_CPU_SPACE
              && pins.address == {IACK_HIGH, cur.level});
   endproperty
   a_iack: assert property (p_iack)
      else $error("acknowledge cycle code or address wrong");
   property p_idle;
      @(posedge clock) disable iff (!reset_n)
      (state == ST_IDLE) |-> (pins.address_strobe_n && pins.rw && pins.data_oe_n
                              && pins.upper_byte_strobe_n && pins.lower_byte_strobe_n);
   endproperty
   a_idle: assert property (p_idle)
      else $error("bus not quiet while idle");
endmodule
`default_nettype wire

//--- testbench/abm_slave.sv
// Behavioural memory slave that ends bus cycles with acknowledge or bus error.
`timescale 1ns/1ps
`default_nettype none
module abm_slave import abm_pkg::*; (
   // Clock and reset.
   input  wire logic       clock,
   input  wire logic       reset_n,
   // Bus side.
   input  wire abm_pins_t  pins,
   output logic [15:0]     data_in,
   output var  logic       transfer_ack_n,
   output var  logic       bus_error_in_n,
   // Answer kind (0 ack, 1 bus error, 2 both) and delay in clocks.
   input  wire logic [1:0] mode,
   input  wire logic [7:0] delay
);
   logic [15:0] mem [16];
   logic [15:0] last;
   logic [7:0]  cnt;
   wire logic       ds = !pins.upper_byte_strobe_n || !pins.lower_byte_strobe_n;
   wire logic       rd = ds && !pins.address_strobe_n && pins.rw;
   wire logic [3:0] idx = pins.address[4:1];

   // Read data shows only while strobed; a released bus wanders.
   assign data_in = rd ? mem[idx] : ~last;

   // Known contents and quiet terminations from time zero.
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = {i[3:0], 4'hC, ~i[3:0], 4'h3};
      last = 16'h0000;
      transfer_ack_n = 1'b1;
      bus_error_in_n = 1'b1;
   end

   // Termination after the delay, held until the byte strobes negate.
   always @(posedge clock) begin
      last <= data_in;
      if (!reset_n || !ds) begin
         cnt <= 8'h00;
         transfer_ack_n <= 1'b1;
         bus_error_in_n <= 1'b1;
      end else begin
         if (cnt != 8'hFF) cnt <= cnt + 8'h01;
         if (cnt >= delay) begin
            transfer_ack_n <= (mode == 2'h1);
            bus_error_in_n <= (mode == 2'h0);
         end
         if (cnt == delay && !pins.rw && mode != 2'h1) begin
            if (!pins.upper_byte_strobe_n) mem[idx][15:8] <= pins.data_out[15:8];
            if (!pins.lower_byte_strobe_n) mem[idx][7:0] <= pins.data_out[7:0];
         end
      end
   end
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the bus cycle master against a memory slave.
`timescale 1ns/1ps
`default_nettype none
module tb import abm_pkg::*; ;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        req_valid = 1'b0;
   abm_req_t    req = '0;
   logic        req_ready;
   logic        done;
   abm_resp_t   resp;
   abm_pins_t   pins;
   logic [15:0] data_in;
   logic        transfer_ack_n;
   logic        bus_error_in_n;
   logic [1:0]  mode = 2'h0;
   logic [7:0]  delay = 8'h02;
   int          failures = 0;
   int          checked = 0;
   int          t_as, t_ds, t_dsr, t_rw, t_oe, t_done, as_falls, ds_falls, tn;
   logic [1:0]  ds_pat;
   logic [2:0]  fc_seen;
   logic [23:1] adr_seen;
   logic [15:0] pre;

   // Clock at 100 MHz.
   always #5 clock = ~clock;

   abm_bus_master u_dut (.clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .done(done), .resp(resp), .pins(pins), .data_in(data_in),
      .transfer_ack_n(transfer_ack_n), .bus_error_in_n(bus_error_in_n));
   abm_slave u_slave (.clock(clock), .reset_n(reset_n), .pins(pins), .data_in(data_in),
      .transfer_ack_n(transfer_ack_n), .bus_error_in_n(bus_error_in_n), .mode(mode),
      .delay(delay));

   ////////////////////////////////////////////////////////////////////////
   // Compare, verdict and one bus cycle with timing capture.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_of_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic [31:0] idle_vec();
      return {27'h0, pins.address_strobe_n, pins.upper_byte_strobe_n,
              pins.lower_byte_strobe_n, pins.rw, pins.data_oe_n};
   endfunction

   task automatic run(input abm_op_t op, input abm_size_t sz, input logic [23:0] addr,
                      input logic [31:0] wd, input logic [2:0] lvl);
      logic pas = 1'b1;
      logic pds = 1'b1;
      logic asn;
      logic dsn;
      {t_as, t_ds, t_dsr, t_rw, t_oe, t_done} = {6{32'hFFFFFFFF}};
      as_falls = 0;
      ds_falls = 0;
      @(posedge clock);
      #1;
      req_valid = 1'b1;
      req = '{op, sz, 3'h5, addr, wd, lvl};
      @(posedge clock);
      #1;
      req_valid = 1'b0;
      // Sample n falls in clock cycle n, the accepting edge being cycle 1.
      for (int n = 2; n < 400 && t_done < 0; n++) begin
         @(posedge clock);
         #1;
         asn = pins.address_strobe_n !== 1'b0;
         dsn = pins.upper_byte_strobe_n !== 1'b0 && pins.lower_byte_strobe_n !== 1'b0;
         if (!asn && pas) as_falls++;
         if (!asn && t_as < 0) begin
            t_as = n;
            fc_seen = pins.function_code;
            adr_seen = pins.address;
         end
         if (!dsn && pds) ds_falls++;
         if (!dsn && t_ds < 0) begin
            t_ds = n;
            ds_pat = {pins.upper_byte_strobe_n, pins.lower_byte_strobe_n};
         end
         if (dsn && !pds && t_dsr < 0) t_dsr = n;
         if (pins.rw === 1'b0 && t_rw < 0) t_rw = n;
         if (pins.data_oe_n === 1'b0 && t_oe < 0) t_oe = n;
         if (done === 1'b1) t_done = n;
         pas = asn;
         pds = dsn;
      end
      chk("done_seen", 32'h1, 32'(t_done > 0));
      chk("idle_pins", 32'h1F, idle_vec());
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_reset;
      chk("req_ready", 32'h1, {31'h0, req_ready});
      chk("idle_pins", 32'h1F, idle_vec());
   endtask

   task automatic t_read;
      delay = 8'h04;
      pre = u_slave.mem[3];
      run(ABM_OP_READ, ABM_SZ_WORD, 24'h000006, 32'h0, 3'h0);
      chk("read_data", {16'h0, pre}, {16'h0, resp.rdata[15:0]});
      chk("word_strobes", 32'h0, {30'h0, ds_pat});
      chk("as_time", 32'h3, t_as);
      chk("ds_time", 32'h3, t_ds);
      chk("rw_low", 32'h0, 32'(t_rw >= 0));
      chk("fc_addr", {6'h0, 3'h5, 23'h000003}, {6'h0, fc_seen, adr_seen});
      tn = t_done;
      delay = 8'h09;
      run(ABM_OP_READ, ABM_SZ_WORD, 24'h000006, 32'h0, 3'h0);
      chk("wait_done", tn + 5, t_done);
   endtask

   task automatic t_byte;
      delay = 8'h02;
      for (int i = 0; i < 2; i++) begin
         pre = u_slave.mem[8];
         run(ABM_OP_READ, ABM_SZ_BYTE, {23'h000008, i[0]}, 32'h0, 3'h0);
         chk("byte_strobe", {30'h0, i[0], ~i[0]}, {30'h0, ds_pat});
         chk("byte_data", {24'h0, i[0] ? pre[7:0] : pre[15:8]}, {24'h0, resp.rdata[7:0]});
         run(ABM_OP_WRITE, ABM_SZ_BYTE, {23'h000008, i[0]}, 32'h000000C5, 3'h0);
         chk("byte_write", i[0] ? {16'h0, pre[15:8], 8'hC5} : {16'h0, 8'hC5, pre[7:0]},
             {16'h0, u_slave.mem[8]});
      end
   endtask

   task automatic t_write;
      run(ABM_OP_WRITE, ABM_SZ_WORD, 24'h00000C, 32'h0000BEEF, 3'h0);
      chk("as_time", 32'h3, t_as);
      chk("rw_time", 32'h3, t_rw);
      chk("oe_time", 32'h4, t_oe);
      chk("ds_time", 32'h5, t_ds);
      chk("word_write", 32'h0000BEEF, {16'h0, u_slave.mem[6]});
      run(ABM_OP_WRITE, ABM_SZ_LONG, 24'h000014, 32'h12345678, 3'h0);
      chk("long_as", 32'h2, as_falls);
      chk("long_write", 32'h12345678, {u_slave.mem[10], u_slave.mem[11]});
      run(ABM_OP_READ, ABM_SZ_LONG, 24'h000014, 32'h0, 3'h0);
      chk("long_read", 32'h12345678, resp.rdata);
   endtask

   task automatic t_bus_error_in;
      run(ABM_OP_READ, ABM_SZ_WORD, 24'h000000, 32'h0, 3'h0);
      tn = t_done;
      mode = 2'h1;
      run(ABM_OP_READ, ABM_SZ_WORD, 24'h000000, 32'h0, 3'h0);
      chk("bus_error_in_err", 32'h1, {31'h0, resp.err});
      chk("bus_error_in_done", tn + 1, t_done);
      run(ABM_OP_WRITE, ABM_SZ_WORD, 24'h000002, 32'h00001111, 3'h0);
      chk("bus_error_in_wr_err", 32'h1, {31'h0, resp.err});
      mode = 2'h2;
      run(ABM_OP_READ, ABM_SZ_WORD, 24'h000000, 32'h0, 3'h0);
      chk("both_done", tn, t_done);
      mode = 2'h0;
   endtask

   task automatic t_rmw;
      pre = u_slave.mem[9];
      run(ABM_OP_RMW, ABM_SZ_BYTE, 24'h000013, 32'h0, 3'h0);
      chk("rmw_as", 32'h1, as_falls);
      chk("rmw_ds", 32'h2, ds_falls);
      chk("rmw_read", {24'h0, pre[7:0]}, {24'h0, resp.rdata[7:0]});
      chk("rmw_rw", t_dsr + 7, t_rw);
      chk("rmw_oe", t_dsr + 8, t_oe);
      chk("rmw_mem", {16'h0, pre[15:8], pre[7:0] | TAS_SET}, {16'h0, u_slave.mem[9]});
      for (int m = 1; m < 3; m++) begin
         mode = m[1:0];
         pre = u_slave.mem[9];
         run(ABM_OP_RMW, ABM_SZ_BYTE, 24'h000013, 32'h0, 3'h0);
         chk("abort_ds", 32'h1, ds_falls);
         chk("abort_err", 32'h1, {31'h0, resp.err});
         chk("abort_mem", {16'h0, pre}, {16'h0, u_slave.mem[9]});
      end
      mode = 2'h0;
   endtask

   task automatic t_iack;
      for (int l = 1; l < 8; l++) begin
         pre = u_slave.mem[{1'b1, l[2:0]}];
         run(ABM_OP_IACK, ABM_SZ_WORD, 24'h000000, 32'h0, l[2:0]);
         chk("iack_fc", 32'h7, {29'h0, fc_seen});
         chk("iack_addr", {9'h0, 20'hFFFFF, l[2:0]}, {9'h0, adr_seen});
         chk("iack_strobes", 32'h0, {30'h0, ds_pat});
         chk("iack_vector", {24'h0, pre[7:0]}, resp.rdata);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence after four clocks of reset.
   initial begin
      repeat (4) @(posedge clock);
      #1;
      reset_n = 1'b1;
      t_reset;
      t_read;
      t_byte;
      t_write;
      t_bus_error_in;
      t_rmw;
      t_iack;
      end_of_test;
   end

   // Watchdog well beyond the few hundred cycles the scenarios need.
   initial begin
      #100000;
      failures++;
      $display("wrong value watchdog expected finished seen hang");
      end_of_test;
   end
endmodule
`default_nettype wire
